// ### rtl/bms_link_if.sv
// Link between the boot sequencer and its partner (host or boot ROM).
// Assumes both ends share clk_sys.
`default_nettype none
interface bms_link_if;
  import bms_pkg::*;
  // Host write/read port into CPU memory
  logic        host_req;
  logic        host_we;
  logic [31:0] host_addr;
  logic [31:0] host_wdata;
  logic        host_ack;
  logic [31:0] host_rdata;
  // Doorbell set strobe and current doorbell level
  logic        doorbell_set;
  logic        doorbell_level;
  // Byte-wide ROM read port on chip-select region one
  logic        rom_req;
  logic [31:0] rom_addr;
  logic        rom_ack;
  logic [7:0]  rom_data;

  modport device (
    input  host_req, host_we, host_addr, host_wdata, doorbell_set, rom_ack, rom_data,
    output host_ack, host_rdata, doorbell_level, rom_req, rom_addr
  );
  modport partner (
    output host_req, host_we, host_addr, host_wdata, doorbell_set, rom_ack, rom_data,
    input  host_ack, host_rdata, doorbell_level, rom_req, rom_addr
  );
endinterface
`default_nettype wire

// ### rtl/bms_partner.sv
// Far end: an external host that loads memory and rings the doorbell,
// plus a byte-wide boot ROM answering the sequencer's copy reads.
// Assumes the same clk_sys as the sequencer; ROM image comes in one byte at a time on rom_byte, addressed by rom_byte_addr.
`default_nettype none
module bms_partner
  import bms_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        load_req,
  input  wire logic        load_we,
  input  wire logic [31:0] load_addr,
  input  wire logic [31:0] load_wdata,
  input  wire logic        load_done,
  input  wire logic [7:0]  rom_byte,
  bms_link_if.partner      link,
  output logic             load_ack,
  output logic [31:0]      load_rdata,
  output logic [31:0]      rom_byte_addr
);
  logic        req_reg, req_next;
  logic        we_reg, we_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] wd_reg, wd_next;
  logic        ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;
  logic        bell_reg, bell_next;
  logic [3:0]  rcnt_reg, rcnt_next;
  logic        rack_reg, rack_next;
  logic [7:0]  rdat_reg, rdat_next;
  logic [31:0] raddr_reg, raddr_next;

  // ----------------------------------------------------------------
  // Host side and ROM side
  // ----------------------------------------------------------------
  always_comb begin
    req_next   = req_reg;
    we_next    = we_reg;
    addr_next  = addr_reg;
    wd_next    = wd_reg;
    ack_next   = 1'h0;
    rd_next    = rd_reg;
    bell_next  = 1'h0;
    rcnt_next  = rcnt_reg;
    rack_next  = 1'h0;
    rdat_next  = rdat_reg;
    raddr_next = raddr_reg;
    // A request held through its own ack cycle is not taken twice
    if (!req_reg && !ack_reg && load_req) begin
      req_next  = 1'h1;
      we_next   = load_we;
      addr_next = load_addr;
      wd_next   = load_wdata;
    end else if (req_reg && link.host_ack) begin
      req_next = 1'h0;
      ack_next = 1'h1;
      rd_next  = link.host_rdata;
    end
    // Ring only when idle, and not while a previous ring is still pending
    if (load_done && !req_reg && !link.doorbell_level) begin
      bell_next = 1'h1;
    end
    // ROM reads take a fixed access time; image order matches system order
    if (link.rom_req && !rack_reg) begin
      raddr_next = link.rom_addr - BMS_CS1_BASE;
      if (rcnt_reg == BMS_ROM_ACC_CNT) begin
        rcnt_next = 4'h0;
        rack_next = 1'h1;
        rdat_next = rom_byte;
      end else begin
        rcnt_next = rcnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      req_reg   <= 1'h0;
      we_reg    <= 1'h0;
      addr_reg  <= BMS_BOOT_ADDR;
      wd_reg    <= 32'h0;
      ack_reg   <= 1'h0;
      rd_reg    <= 32'h0;
      bell_reg  <= 1'h0;
      rcnt_reg  <= 4'h0;
      rack_reg  <= 1'h0;
      rdat_reg  <= 8'h0;
      raddr_reg <= BMS_DOORBELL_RST;
    end else if (clk_en) begin
      req_reg   <= req_next;
      we_reg    <= we_next;
      addr_reg  <= addr_next;
      wd_reg    <= wd_next;
      ack_reg   <= ack_next;
      rd_reg    <= rd_next;
      bell_reg  <= bell_next;
      rcnt_reg  <= rcnt_next;
      rack_reg  <= rack_next;
      rdat_reg  <= rdat_next;
      raddr_reg <= raddr_next;
    end
  end

  assign link.host_req     = req_reg;
  assign link.host_we      = we_reg;
  assign link.host_addr    = addr_reg;
  assign link.host_wdata   = wd_reg;
  assign link.doorbell_set = bell_reg;
  assign link.rom_ack      = rack_reg;
  assign link.rom_data     = rdat_reg;
  assign load_ack          = ack_reg;
  assign load_rdata        = rd_reg;
  // Valid code at zero in no-boot mode is the system's job, not this end's
  assign rom_byte_addr     = raddr_reg;
endmodule
`default_nettype wire

// ### rtl/bms_pkg.sv
// Shared constants and types for the boot mode sequencer and its boot partner.
// Assumes a single 100 MHz clock shared by both ends.
`default_nettype none
package bms_pkg;
  // ----------------------------------------------------------------
  // Boot modes and strap encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BMS_MODE_NONE = 2'h0,
    BMS_MODE_HOST = 2'h1,
    BMS_MODE_ROM  = 2'h2
  } bms_mode_t;
  localparam logic BMS_SEL_HOST_PORT = 1'h0;
  localparam logic BMS_SEL_PCI       = 1'h1;

  // ----------------------------------------------------------------
  // Memory image layout
  // ----------------------------------------------------------------
  localparam int          BMS_ROM_BYTES   = 1024;
  localparam int          BMS_ROM_WORDS   = BMS_ROM_BYTES / 4;
  localparam logic [31:0] BMS_CS1_BASE    = 32'h9000_0000;
  localparam logic [31:0] BMS_BOOT_ADDR   = 32'h0000_0000;
  localparam logic [31:0] BMS_ADDR_STEP   = 32'h0000_0004;
  localparam logic [31:0] BMS_DOORBELL_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          BMS_CLK_MHZ     = 100;
  localparam int          BMS_ROM_ACC_NS  = 20;
  localparam int          BMS_ROM_ACC_CYC = (BMS_ROM_ACC_NS * BMS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  BMS_ROM_ACC_CNT = 4'(BMS_ROM_ACC_CYC);
endpackage
`default_nettype wire

// ### rtl/bms_sequencer.sv
// Boot configuration logic: holds the CPU stalled per strapped boot mode,
// serves host loads, copies the boot ROM image, then releases the CPU.
// Assumes straps come from pins and the link from same-clock partner logic.
`default_nettype none
// Behaviour
// - Active-low reset holds everything in reset state
// - Start in the strapped boot mode after reset
// - Host mode: stall CPU, release the rest
// - Host may write any memory while stalled
// - Strap selects host port or PCI path
// - Host sets doorbell to finish host boot
// - Doorbell releases stall, CPU fetches at zero
// - Boot doorbell is not a pending interrupt
// - Doorbell releases stall only in host mode
// - Host may read back all memory
// - CPU clears doorbell; set doorbell blocks more
// - ROM mode copies 1 KB from region one
// - Pack four ROM bytes into each word
// - Copy is one single-frame block transfer
// - Copy done releases stall, fetch at zero
// - ROM image stored in system byte order
// - No-boot mode runs from zero immediately
// - System supplies valid code at zero
module bms_sequencer
  import bms_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic [1:0]  boot_mode_pin,
  input  wire logic        pci_sel_pin,
  input  wire logic        cpu_doorbell_clr,
  bms_link_if.device       link,
  output logic             cpu_stall,
  output logic             periph_rst_b,
  output logic [31:0]      cpu_fetch_addr,
  output logic             host_path_pci,
  output logic             doorbell_irq,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic [31:0] mem_rdata
);
  typedef enum logic [2:0] {
    ST_RESET, ST_SAMPLE, ST_HOST, ST_COPY_REQ, ST_COPY_WAIT, ST_RUN
  } bms_state_t;

  // ----------------------------------------------------------------
  // Strap synchronisers
  // ----------------------------------------------------------------
  logic [1:0] mode_s1_reg, mode_s2_reg, mode_s3_reg;
  logic       pci_s1_reg, pci_s2_reg, pci_s3_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_s1_reg <= 2'h3;
      mode_s2_reg <= 2'h0;
      mode_s3_reg <= 2'h3;
      pci_s1_reg  <= 1'h1;
      pci_s2_reg  <= 1'h0;
      pci_s3_reg  <= 1'h1;
    end else if (clk_en) begin
      mode_s1_reg <= boot_mode_pin;
      mode_s2_reg <= mode_s1_reg;
      mode_s3_reg <= mode_s2_reg;
      pci_s1_reg  <= pci_sel_pin;
      pci_s2_reg  <= pci_s1_reg;
      pci_s3_reg  <= pci_s2_reg;
    end
  end
  // Stages 2 and 3 reset apart, so agreement means the pins have filled the chain
  wire strap_stable = (mode_s2_reg == mode_s3_reg) && (pci_s2_reg == pci_s3_reg);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  bms_state_t  state_reg, state_next;
  bms_mode_t   mode_reg, mode_next;
  logic        pci_reg, pci_next;
  logic        stall_reg, stall_next;
  logic        prst_reg, prst_next;
  logic        bell_reg, bell_next;
  logic        irq_reg, irq_next;
  logic [7:0]  word_reg, word_next;
  logic [1:0]  byte_reg, byte_next;
  logic [23:0] pack_reg, pack_next;
  logic        rreq_reg, rreq_next;
  logic [31:0] raddr_reg, raddr_next;
  logic        hack_reg, hack_next;
  logic [31:0] hrd_reg, hrd_next;
  logic        we_reg, we_next;
  logic [31:0] ma_reg, ma_next;
  logic [31:0] mwd_reg, mwd_next;

  function automatic bms_mode_t decode_mode(input logic [1:0] code);
    unique case (code)
      2'h1:    decode_mode = BMS_MODE_HOST;
      2'h2:    decode_mode = BMS_MODE_ROM;
      default: decode_mode = BMS_MODE_NONE;
    endcase
  endfunction

  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    pci_next   = pci_reg;
    stall_next = stall_reg;
    prst_next  = prst_reg;
    bell_next  = bell_reg;
    irq_next   = irq_reg;
    word_next  = word_reg;
    byte_next  = byte_reg;
    pack_next  = pack_reg;
    rreq_next  = rreq_reg;
    raddr_next = raddr_reg;
    hack_next  = 1'h0;
    hrd_next   = hrd_reg;
    we_next    = 1'h0;
    ma_next    = ma_reg;
    mwd_next   = mwd_reg;

    // Doorbell: CPU clear wins over a host set while set; only a clear reopens it
    if (cpu_doorbell_clr) begin
      bell_next = 1'h0;
    end
    if (link.doorbell_set && !bell_reg) begin
      bell_next = 1'h1;
      // Only a doorbell seen after the CPU runs becomes an interrupt
      irq_next  = (state_reg == ST_RUN);
    end else begin
      irq_next = 1'h0;
    end

    // Host access into CPU memory, open outside reset
    if (link.host_req && !hack_reg && prst_reg) begin
      hack_next = 1'h1;
      we_next   = link.host_we;
      ma_next   = link.host_addr;
      mwd_next  = link.host_wdata;
      hrd_next  = mem_rdata;
    end

    unique case (state_reg)
      ST_RESET: begin
        stall_next = 1'h1;
        if (strap_stable) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        mode_next = decode_mode(mode_s3_reg);
        pci_next  = pci_s3_reg;
        prst_next = 1'h1;
        unique case (decode_mode(mode_s3_reg))
          BMS_MODE_HOST: state_next = ST_HOST;
          BMS_MODE_ROM: begin
            state_next = ST_COPY_REQ;
            raddr_next = BMS_CS1_BASE;
            word_next  = 8'h0;
            byte_next  = 2'h0;
          end
          BMS_MODE_NONE: begin
            state_next = ST_RUN;
            stall_next = 1'h0;
          end
        endcase
      end
      ST_HOST: begin
        // Release only on the host mode doorbell edge
        if (link.doorbell_set && !bell_reg) begin
          state_next = ST_RUN;
          stall_next = 1'h0;
        end
      end
      ST_COPY_REQ: begin
        // Host may still write memory; the copy shares the port
        if (!(link.host_req && !hack_reg)) begin
          rreq_next  = 1'h1;
          state_next = ST_COPY_WAIT;
        end
      end
      ST_COPY_WAIT: begin
        if (rreq_reg && link.rom_ack) begin
          rreq_next  = 1'h0;
          raddr_next = raddr_reg + 32'h1;
          byte_next  = byte_reg + 2'h1;
          // First byte lands in the low lane: system byte order is little end
          if (byte_reg == 2'h3) begin
            we_next    = 1'h1;
            ma_next    = BMS_BOOT_ADDR + {22'h0, word_reg, 2'h0};
            mwd_next   = {link.rom_data, pack_reg};
            word_next  = word_reg + 8'h1;
            // One frame of all words, no gaps between frames
            if (word_reg == 8'(BMS_ROM_WORDS - 1)) begin
              state_next = ST_RUN;
              stall_next = 1'h0;
            end else begin
              state_next = ST_COPY_REQ;
            end
          end else begin
            pack_next  = {link.rom_data, pack_reg[23:8]};
            state_next = ST_COPY_REQ;
          end
        end
      end
      ST_RUN: begin
        stall_next = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_RESET;
      mode_reg  <= BMS_MODE_NONE;
      pci_reg   <= BMS_SEL_HOST_PORT;
      stall_reg <= 1'h1;
      prst_reg  <= 1'h0;
      bell_reg  <= 1'h0;
      irq_reg   <= 1'h0;
      word_reg  <= 8'h0;
      byte_reg  <= 2'h0;
      pack_reg  <= 24'h0;
      rreq_reg  <= 1'h0;
      raddr_reg <= BMS_CS1_BASE;
      hack_reg  <= 1'h0;
      hrd_reg   <= 32'h0;
      we_reg    <= 1'h0;
      ma_reg    <= BMS_BOOT_ADDR;
      mwd_reg   <= 32'h0;
    end else if (clk_en) begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      pci_reg   <= pci_next;
      stall_reg <= stall_next;
      prst_reg  <= prst_next;
      bell_reg  <= bell_next;
      irq_reg   <= irq_next;
      word_reg  <= word_next;
      byte_reg  <= byte_next;
      pack_reg  <= pack_next;
      rreq_reg  <= rreq_next;
      raddr_reg <= raddr_next;
      hack_reg  <= hack_next;
      hrd_reg   <= hrd_next;
      we_reg    <= we_next;
      ma_reg    <= ma_next;
      mwd_reg   <= mwd_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cpu_stall           = stall_reg;
  assign periph_rst_b        = prst_reg;
  assign cpu_fetch_addr      = BMS_BOOT_ADDR;
  assign host_path_pci       = pci_reg;
  assign doorbell_irq        = irq_reg;
  assign mem_we              = we_reg;
  assign mem_addr            = ma_reg;
  assign mem_wdata           = mwd_reg;
  assign link.host_ack       = hack_reg;
  assign link.host_rdata     = hrd_reg;
  assign link.doorbell_level = bell_reg;
  assign link.rom_req        = rreq_reg;
  assign link.rom_addr       = raddr_reg;
endmodule
`default_nettype wire

// ### verif/bms_link_sva.sv
// Checker for the link between the boot sequencer and its partner.
// Assumes one clock domain; instantiated beside the link in tb_top.
`default_nettype none
module bms_link_sva
  import bms_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        host_req,
  input wire logic        host_we,
  input wire logic [31:0] host_addr,
  input wire logic        host_ack,
  input wire logic        doorbell_set,
  input wire logic        doorbell_level,
  input wire logic        rom_req,
  input wire logic [31:0] rom_addr,
  input wire logic        rom_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Host access
  // ----------------------------------------------------------------
  property p_ack_pulse; host_ack |=> !host_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("host ack longer than one cycle");
  property p_ack_cause; host_ack |-> $past(host_req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("host ack without request");
  property p_req_hold;
    host_req && !host_ack |=> host_req && $stable(host_addr) && $stable(host_we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("host request changed before ack");

  // ----------------------------------------------------------------
  // Doorbell
  // ----------------------------------------------------------------
  property p_db_pulse; doorbell_set |=> !doorbell_set; endproperty
  a_db_pulse: assert property (p_db_pulse) else $error("doorbell set not a pulse");
  property p_db_take; doorbell_set && !doorbell_level |=> doorbell_level; endproperty
  a_db_take: assert property (p_db_take) else $error("doorbell not latched");
  property p_db_cause; $rose(doorbell_level) |-> $past(doorbell_set); endproperty
  a_db_cause: assert property (p_db_cause) else $error("doorbell rose without set");

  // ----------------------------------------------------------------
  // ROM copy reads
  // ----------------------------------------------------------------
  property p_rom_lat; $rose(rom_req) |-> !rom_ack [*3] ##1 rom_ack; endproperty
  a_rom_lat: assert property (p_rom_lat) else $error("ROM answer latency wrong");
  property p_rom_hold; rom_req && !rom_ack |=> rom_req && $stable(rom_addr); endproperty
  a_rom_hold: assert property (p_rom_hold) else $error("ROM request changed early");
  property p_rom_step; rom_ack |=> !rom_req; endproperty
  a_rom_step: assert property (p_rom_step) else $error("ROM request not dropped after ack");
  property p_rom_range;
    rom_req |-> rom_addr >= BMS_CS1_BASE && rom_addr < BMS_CS1_BASE + 32'(BMS_ROM_BYTES);
  endproperty
  a_rom_range: assert property (p_rom_range) else $error("ROM read outside image");

  c_host: cover property (host_ack && host_we);
  c_db: cover property ($rose(doorbell_level));
  c_rom_last: cover property (rom_ack && rom_addr == BMS_CS1_BASE + 32'h0000_03ff);
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench: sequencer and partner joined by the link.
// Assumes the bench supplies straps, CPU memory read data and the ROM image.
`default_nettype none
module tb_top
  import bms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_b, clk_en, pci_sel_pin, cpu_doorbell_clr;
  logic [1:0]  boot_mode_pin;
  logic        cpu_stall, periph_rst_b, host_path_pci, doorbell_irq, mem_we;
  logic [31:0] cpu_fetch_addr, mem_addr, mem_wdata, mem_rdata, load_addr, load_wdata, load_rdata, rom_byte_addr;
  logic        load_req, load_we, load_done, load_ack;
  logic [7:0]  rom_byte;
  int          mismatches, n_tests, wr_cnt, irq_cnt, i;
  logic        rom_chk;
  integer      seed;
  bms_link_if link();

  bms_sequencer u_bms_sequencer (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .boot_mode_pin(boot_mode_pin), .pci_sel_pin(pci_sel_pin), .cpu_doorbell_clr(cpu_doorbell_clr),
    .link(link), .cpu_stall(cpu_stall), .periph_rst_b(periph_rst_b), .cpu_fetch_addr(cpu_fetch_addr),
    .host_path_pci(host_path_pci), .doorbell_irq(doorbell_irq), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  bms_partner u_bms_partner (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .load_req(load_req),
    .load_we(load_we), .load_addr(load_addr), .load_wdata(load_wdata), .load_done(load_done),
    .rom_byte(rom_byte), .link(link), .load_ack(load_ack), .load_rdata(load_rdata),
    .rom_byte_addr(rom_byte_addr));
  bms_link_sva u_bms_link_sva (.clk_sys(clk_sys), .rst_b(rst_b), .host_req(link.host_req),
    .host_we(link.host_we), .host_addr(link.host_addr), .host_ack(link.host_ack),
    .doorbell_set(link.doorbell_set), .doorbell_level(link.doorbell_level), .rom_req(link.rom_req),
    .rom_addr(link.rom_addr), .rom_ack(link.rom_ack));

  // ----------------------------------------------------------------
  // Memory models and expectations
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_fn(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  function automatic logic [7:0] rom_fn(input logic [31:0] a);
    return a[7:0] ^ 8'h5c ^ {4{a[9:8]}};
  endfunction
  // Little endian: first byte read lands in bits 7:0
  function automatic logic [31:0] word_fn(input int w);
    return {rom_fn(32'(4*w+3)), rom_fn(32'(4*w+2)), rom_fn(32'(4*w+1)), rom_fn(32'(4*w))};
  endfunction
  assign mem_rdata = rd_fn(link.host_addr);
  assign rom_byte  = rom_fn(rom_byte_addr);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Write monitor; during a ROM copy each word is checked as it lands
  always @(posedge clk_sys) begin
    if (doorbell_irq) irq_cnt++;
    if (mem_we) begin
      if (rom_chk) begin
        check("copy addr", mem_addr, BMS_BOOT_ADDR + 32'(4*wr_cnt));
        check("copy word", mem_wdata, word_fn(wr_cnt));
      end
      wr_cnt++;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic host_access(input logic we, input logic [31:0] a, input logic [31:0] d);
    int t;
    int w0;
    w0 = wr_cnt;
    @(posedge clk_sys);
    load_req <= 1'b1; load_we <= we; load_addr <= a; load_wdata <= d;
    t = 0;
    do begin @(posedge clk_sys); t++; end while (load_ack !== 1'b1 && t < 20);
    load_req <= 1'b0;
    check("host ack", 32'(load_ack), 32'h1);
    if (we) begin
      check("write count", 32'(wr_cnt - w0), 32'h1);
      check("write addr", mem_addr, a);
      check("write data", mem_wdata, d);
    end else
      check("read back", load_rdata, rd_fn(a));
  endtask

  task automatic ring;
    @(posedge clk_sys);
    load_done <= 1'b1;
    @(posedge clk_sys);
    load_done <= 1'b0;
    cyc(6);
  endtask

  task automatic run_mode(input logic [1:0] mode);
    logic p;
    int t;
    p = 1'($random(seed));
    @(posedge clk_sys);
    rst_b <= 1'b0; boot_mode_pin <= mode; pci_sel_pin <= p; rom_chk <= (mode == BMS_MODE_ROM);
    cyc(4);
    check("stall in reset", 32'(cpu_stall), 32'h1);
    check("periph in reset", 32'(periph_rst_b), 32'h0);
    wr_cnt = 0;
    irq_cnt = 0;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    boot_mode_pin <= 2'($random(seed));
    pci_sel_pin <= ~p;
    t = 0;
    while (periph_rst_b !== 1'b1 && t < 30) begin cyc(1); t++; end
    check("periph released", 32'(periph_rst_b), 32'h1);
    check("stall at start", 32'(cpu_stall), 32'(mode == BMS_MODE_HOST || mode == BMS_MODE_ROM));
    check("path select", 32'(host_path_pci), 32'(p));
    check("fetch addr", cpu_fetch_addr, BMS_BOOT_ADDR);
    if (mode == BMS_MODE_HOST) begin
      for (i = 0; i < 4; i++) begin
        host_access(1'b1, (i == 0) ? 32'hffff_fffc : 32'($random(seed)) & 32'hffff_fffc, $random(seed));
        host_access(1'b0, 32'($random(seed)) & 32'hffff_fffc, 32'h0);
      end
      clk_en <= 1'b0;
      ring();
      check("stall while frozen", 32'(cpu_stall), 32'h1);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      check("stall before bell", 32'(cpu_stall), 32'h1);
      ring();
      check("stall after bell", 32'(cpu_stall), 32'h0);
      check("bell level", 32'(link.doorbell_level), 32'h1);
      ring();
      check("no irq while set", 32'(irq_cnt), 32'h0);
      @(posedge clk_sys);
      cpu_doorbell_clr <= 1'b1;
      @(posedge clk_sys);
      cpu_doorbell_clr <= 1'b0;
      cyc(2);
      check("bell cleared", 32'(link.doorbell_level), 32'h0);
      ring();
      check("irq once running", 32'(irq_cnt), 32'h1);
    end else if (mode == BMS_MODE_ROM) begin
      ring();
      check("bell no release", 32'(cpu_stall), 32'h1);
      t = 0;
      while (cpu_stall !== 1'b0 && t < 8000) begin cyc(1); t++; end
      cyc(1);
      check("copy words", 32'(wr_cnt), 32'(BMS_ROM_WORDS));
      check("stall after copy", 32'(cpu_stall), 32'h0);
    end else begin
      ring();
      check("no boot runs", 32'(cpu_stall), 32'h0);
      check("no copy", 32'(wr_cnt), 32'h0);
    end
  endtask

  initial begin
    seed = 32'h671239f8;
    mismatches = 0; n_tests = 0; wr_cnt = 0; irq_cnt = 0;
    rst_b = 1'b0; clk_en = 1'b1; boot_mode_pin = 2'h0; pci_sel_pin = 1'b0; cpu_doorbell_clr = 1'b0;
    load_req = 1'b0; load_we = 1'b0; load_addr = 32'h0; load_wdata = 32'h0; load_done = 1'b0;
    rom_chk = 1'b0;
    cyc(4);
    run_mode(BMS_MODE_HOST);
    run_mode(BMS_MODE_NONE);
    run_mode(2'h3);
    run_mode(BMS_MODE_ROM);
    run_mode(BMS_MODE_HOST);
    stop_test();
  end

  // Whole run is near 5400 cycles; allow ample margin
  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
